// file: half_flash_adc_sequencer.sv
// sequencer for an 8-bit two-stage half-flash converter
// assumes ladder outputs are synchronous to CLOCK and the control word is valid only with CTRL_WRITE
// Function
// - eight-bit result from two half-flash stages with separate nibble ladders
// - upper nibble first; it selects the ladder segment for the lower nibble
// - each stage's 31 thermometer comparator outputs become binary in logic
// - sample rates 8, 16, 32, 64 or 128 kHz from the system clock
// - a dedicated sample-rate timer paces sampling
// - comparators are auto-zeroed while sampling, before conversion
// - a start bit write with the enable bit set begins a conversion at any time
// - a start during a conversion aborts it and begins a fresh one
// - a new rate setting takes effect only at the next start; the enable bit takes effect on its write
// - an enable bit selects low-power disable or operation
// - a conversion takes no less than 2 microseconds start to result
module half_flash_adc_sequencer (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        CTRL_WRITE,
    input  wire logic        CTRL_START,
    input  wire logic        CTRL_ENABLE,
    input  wire logic [2:0]  CTRL_RATE,
    input  wire logic [30:0] COARSE_LADDER,
    input  wire logic [30:0] FINE_LADDER,
    output logic             AUTO_ZERO,
    output logic             SAMPLE_HOLD,
    output logic             COARSE_LATCH,
    output logic             FINE_LATCH,
    output logic [3:0]       SEGMENT_SEL,
    output logic             POWER_DOWN,
    output logic             BUSY,
    output logic             SAMPLE_TICK,
    output logic [7:0]       RESULT,
    output logic             DONE
);
    adc_seq_pkg::state_type state_q;
    logic [9:0]  phase_q;
    logic [2:0]  rate_q;
    logic        enable_q;
    logic        run_q;
    logic [14:0] timer_q;
    logic [14:0] period;
    logic        tick;
    logic        start_cmd;
    logic [3:0]  upper_q;
    logic        enable_now;

    thermo_if coarse_if ();
    thermo_if fine_if ();
    assign coarse_if.pattern = COARSE_LADDER;
    assign fine_if.pattern   = FINE_LADDER;

    thermo_encoder u_coarse (.tif(coarse_if));
    thermo_encoder u_fine   (.tif(fine_if));

    assign start_cmd = CTRL_WRITE && CTRL_START && CTRL_ENABLE;

    // the rate is captured only with a start so a running conversion keeps its own
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rate_q <= adc_seq_pkg::RATE_8K;
        end else if (start_cmd) begin
            rate_q <= CTRL_RATE;
        end
    end

    // the rate timer runs from a start until a write clears the enable bit
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            run_q <= 1'b0;
        end else if (CTRL_WRITE && !CTRL_ENABLE) begin
            run_q <= 1'b0;
        end else if (start_cmd) begin
            run_q <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            enable_q <= 1'b0;
        end else if (CTRL_WRITE) begin
            enable_q <= CTRL_ENABLE;
        end
    end

    // a write that enables and starts at once must not lose its start to enable_q lag
    assign enable_now = CTRL_WRITE ? CTRL_ENABLE : enable_q;

    // codes above 128 kHz fall back to the slowest rate
    always_comb begin
        if (rate_q > adc_seq_pkg::RATE_128K) begin
            period = 15'(adc_seq_pkg::BASE_PERIOD_CYC - 1);
        end else begin
            period = 15'((adc_seq_pkg::BASE_PERIOD_CYC >> rate_q) - 1);
        end
    end

    // sample-rate timer; a start restarts it so the first tick follows one full period later
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            timer_q <= 15'h0000;
        end else if (start_cmd || !run_q || !enable_q) begin
            timer_q <= 15'h0000;
        end else if (timer_q >= period) begin
            timer_q <= 15'h0000;
        end else begin
            timer_q <= timer_q + 15'h0001;
        end
    end

    // ticks landing mid-conversion are dropped; only an idle sequencer takes them
    assign tick = run_q && enable_q && (timer_q >= period) && !start_cmd;

    // a start outranks every phase, so a running conversion just begins again
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            phase_q <= 10'h000;
        end else if (!enable_now) begin
            state_q <= adc_seq_pkg::ST_IDLE;
            phase_q <= 10'h000;
        end else if (start_cmd || (tick && state_q == adc_seq_pkg::ST_IDLE)) begin
            state_q <= adc_seq_pkg::ST_ZERO;
            phase_q <= 10'h000;
        end else begin
            case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                    phase_q <= 10'h000;
                end
                adc_seq_pkg::ST_ZERO: begin
                    if (phase_q == 10'(adc_seq_pkg::ZERO_CYC - 1)) begin
                        state_q <= adc_seq_pkg::ST_COARSE;
                        phase_q <= 10'h000;
                    end else begin
                        phase_q <= phase_q + 10'h001;
                    end
                end
                adc_seq_pkg::ST_COARSE: begin
                    if (phase_q == 10'(adc_seq_pkg::COARSE_CYC - 1)) begin
                        state_q <= adc_seq_pkg::ST_FINE;
                        phase_q <= 10'h000;
                    end else begin
                        phase_q <= phase_q + 10'h001;
                    end
                end
                adc_seq_pkg::ST_FINE: begin
                    if (phase_q == 10'(adc_seq_pkg::FINE_CYC - 1)) begin
                        state_q <= adc_seq_pkg::ST_IDLE;
                        phase_q <= 10'h000;
                    end else begin
                        phase_q <= phase_q + 10'h001;
                    end
                end
                default: begin
                    state_q <= adc_seq_pkg::ST_IDLE;
                    phase_q <= 10'h000;
                end
            endcase
        end
    end

    logic coarse_end;
    logic fine_end;
    logic conv_live;
    assign conv_live  = enable_now && !start_cmd;
    assign coarse_end = conv_live && state_q == adc_seq_pkg::ST_COARSE
                        && phase_q == 10'(adc_seq_pkg::COARSE_CYC - 1);
    assign fine_end   = conv_live && state_q == adc_seq_pkg::ST_FINE
                        && phase_q == 10'(adc_seq_pkg::FINE_CYC - 1);

    // upper nibble saturates at 15 so the segment select stays in range
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            upper_q <= 4'h0;
        end else if (coarse_end) begin
            upper_q <= (coarse_if.level[4:1] == 4'hF) ? 4'hF : coarse_if.level[4:1];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RESULT <= adc_seq_pkg::RESULT_RESET;
            DONE   <= 1'b0;
        end else begin
            DONE <= fine_end;
            if (fine_end) begin
                RESULT <= {upper_q, fine_if.level[4:1]};
            end
        end
    end

    // analog controls, registered from the state for glitch-free switching
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            AUTO_ZERO    <= 1'b0;
            SAMPLE_HOLD  <= 1'b0;
            COARSE_LATCH <= 1'b0;
            FINE_LATCH   <= 1'b0;
            SEGMENT_SEL  <= 4'h0;
        end else begin
            AUTO_ZERO    <= state_q == adc_seq_pkg::ST_ZERO;
            SAMPLE_HOLD  <= state_q == adc_seq_pkg::ST_COARSE
                            || state_q == adc_seq_pkg::ST_FINE;
            COARSE_LATCH <= coarse_end;
            FINE_LATCH   <= fine_end;
            SEGMENT_SEL  <= upper_q;
        end
    end

    // status seen by the core; power-down is high out of reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            POWER_DOWN   <= 1'b1;
            BUSY         <= 1'b0;
            SAMPLE_TICK  <= 1'b0;
        end else begin
            POWER_DOWN   <= !enable_q;
            BUSY         <= state_q != adc_seq_pkg::ST_IDLE;
            SAMPLE_TICK  <= tick;
        end
    end
endmodule : half_flash_adc_sequencer

// file: adc_seq_pkg.sv
// constants for the half-flash converter sequencer
// assumes a 200 MHz system clock on CLOCK
package adc_seq_pkg;
    localparam int CLOCK_MHZ        = 200;
    localparam int REF_CLOCK_KHZ    = 20480;
    // rate field codes: 8, 16, 32, 64, 128 kHz
    localparam logic [2:0] RATE_8K   = 3'h0;
    localparam logic [2:0] RATE_16K  = 3'h1;
    localparam logic [2:0] RATE_32K  = 3'h2;
    localparam logic [2:0] RATE_64K  = 3'h3;
    localparam logic [2:0] RATE_128K = 3'h4;
    localparam int BASE_RATE_KHZ    = 8;
    // sample period at 8 kHz in clock cycles
    localparam int BASE_PERIOD_CYC  = CLOCK_MHZ * 1000 / BASE_RATE_KHZ;
    localparam int TIMER_W          = 15;
    // least conversion time, start to result
    localparam int CONV_MIN_NS      = 2000;
    localparam int CLK_PERIOD_NS    = 5;
    localparam int CONV_MIN_CYC     = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // phase lengths: sample+auto-zero, coarse, fine; total reaches the least time
    localparam int ZERO_CYC         = 200;
    localparam int COARSE_CYC       = 150;
    localparam int FINE_CYC         = CONV_MIN_CYC - ZERO_CYC - COARSE_CYC;
    localparam int PHASE_W          = 10;
    localparam int THERMO_W         = 31;
    localparam int NIBBLE_W         = 4;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ZERO   = 4'h2,
        ST_COARSE = 4'h4,
        ST_FINE   = 4'h8
    } state_type;
endpackage : adc_seq_pkg

// file: thermo_if.sv
// carries one comparator ladder pattern and its encoded value
// assumes the ladder pattern is stable while sampled
interface thermo_if;
    logic [30:0] pattern;
    logic [4:0]  level;
    modport encoder (input pattern, output level);
    modport user    (output pattern, input level);
endinterface : thermo_if

// file: thermo_encoder.sv
// thermometer to binary encoder for one 31-comparator ladder
// assumes comparators above the input read zero, below read one
module thermo_encoder (
    thermo_if.encoder tif
);
    logic [4:0] ones [0:31];
    // counting ones tolerates a single bubble better than a priority search
    assign ones[0] = 5'h00;
    genvar g;
    generate
        for (g = 0; g < adc_seq_pkg::THERMO_W; g++) begin : g_cnt
            assign ones[g+1] = ones[g] + {4'h0, tif.pattern[g]};
        end
    endgenerate
    assign tif.level = ones[31];
endmodule : thermo_encoder

// file: half_flash_adc_monitor.sv
// port-level assertions for the converter sequencer
// assumes it is bound to the sequencer with all ports by name
module half_flash_adc_monitor (
    input wire logic       CLOCK,
    input wire logic       RST_N,
    input wire logic       CTRL_WRITE,
    input wire logic       CTRL_START,
    input wire logic       CTRL_ENABLE,
    input wire logic       AUTO_ZERO,
    input wire logic       SAMPLE_HOLD,
    input wire logic       COARSE_LATCH,
    input wire logic       FINE_LATCH,
    input wire logic [3:0] SEGMENT_SEL,
    input wire logic       POWER_DOWN,
    input wire logic       BUSY,
    input wire logic       SAMPLE_TICK,
    input wire logic [7:0] RESULT,
    input wire logic       DONE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [9:0] busy_q;
    // saturates so a long run of back-to-back conversions cannot wrap
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) busy_q <= '0;
        else if (!BUSY) busy_q <= '0;
        else if (busy_q != 10'h3FF) busy_q <= busy_q + 10'h1;
    end
    a_start_zero: assert property (CTRL_WRITE && CTRL_START && CTRL_ENABLE |-> ##[1:3] AUTO_ZERO)
        else $error("no auto-zero after start");
    a_zero_excl: assert property (!(AUTO_ZERO && SAMPLE_HOLD))
        else $error("auto-zero overlaps hold");
    a_hold_after_zero: assert property ($rose(SAMPLE_HOLD) |-> $past(AUTO_ZERO))
        else $error("hold without auto-zero");
    a_done_fine: assert property (DONE |-> FINE_LATCH)
        else $error("done without fine latch");
    a_min_time: assert property (DONE |-> busy_q >= 10'd399)
        else $error("conversion too short");
    a_seg_result: assert property (DONE |-> RESULT[7:4] == SEGMENT_SEL)
        else $error("upper nibble differs from segment");
    a_result_hold: assert property (!DONE |-> $stable(RESULT))
        else $error("result moved without done");
    a_off_power: assert property (CTRL_WRITE && !CTRL_ENABLE |-> ##[1:3] POWER_DOWN)
        else $error("no power down");
    a_off_quiet: assert property (POWER_DOWN |-> !DONE)
        else $error("done while powered down");
    a_tick_pulse: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("tick longer than a cycle");
    a_latch_order: assert property (COARSE_LATCH |-> SAMPLE_HOLD && !FINE_LATCH)
        else $error("coarse latch outside hold");
endmodule : half_flash_adc_monitor
bind half_flash_adc_sequencer half_flash_adc_monitor i_mon (.*);

// file: ctrl_core_model.sv
// core-side model writing the analog control register
// assumes calls only after reset release; released fields go to inverse
module ctrl_core_model (
    input  wire logic clock,
    output logic       ctrl_write,
    output logic       ctrl_start,
    output logic       ctrl_enable,
    output logic [2:0] ctrl_rate
);
    initial {ctrl_write, ctrl_start, ctrl_enable, ctrl_rate} = '0;
    task write_ctrl(input logic en, input logic st, input logic [2:0] rate);
        @(negedge clock);
        ctrl_write = 1'b1;
        {ctrl_enable, ctrl_start, ctrl_rate} = {en, st, rate};
        @(negedge clock);
        ctrl_write = 1'b0;
        {ctrl_enable, ctrl_start, ctrl_rate} = ~{en, st, rate};
    endtask : write_ctrl
endmodule : ctrl_core_model

// file: half_flash_adc_sequencer_tb.sv
// self-checking bench for the converter sequencer
// assumes ladders are held steady by the bench during a conversion
module half_flash_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0;
    logic [30:0] coarse = '0, fine = '0;
    logic wr, st, en, az, sh, cl, fl, pd, busy, tick, done;
    logic [2:0] rate;
    logic [3:0] seg;
    logic [7:0] result;
    int seed = 32'h6881abd3, fail_count = 0, n_compared = 0, n, kc, kf, ncl;
    int exp_q[$];
    always #2.5 clock = ~clock;
    ctrl_core_model i_core (.clock(clock), .ctrl_write(wr), .ctrl_start(st),
        .ctrl_enable(en), .ctrl_rate(rate));
    half_flash_adc_sequencer i_dut (.CLOCK(clock), .RST_N(rst_n), .CTRL_WRITE(wr),
        .CTRL_START(st), .CTRL_ENABLE(en), .CTRL_RATE(rate), .COARSE_LADDER(coarse),
        .FINE_LADDER(fine), .AUTO_ZERO(az), .SAMPLE_HOLD(sh), .COARSE_LATCH(cl),
        .FINE_LATCH(fl), .SEGMENT_SEL(seg), .POWER_DOWN(pd), .BUSY(busy),
        .SAMPLE_TICK(tick), .RESULT(result), .DONE(done));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
            fail_count++;
        end
    endtask : check
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // thermometer of level k; expected nibble is k halved
    task set_ladders;
        kc = $unsigned($random(seed)) % 32;
        kf = $unsigned($random(seed)) % 32;
        coarse = (31'h1 << kc) - 31'h1;
        fine = (31'h1 << kf) - 31'h1;
        exp_q.delete(); // an aborted start never yields its result
        exp_q.push_back(((kc >> 1) << 4) | (kf >> 1));
    endtask : set_ladders
    task wait_done(output int cnt);
        cnt = 0;
        ncl = 0;
        while (done !== 1'b1 && cnt < 1000) begin
            @(negedge clock);
            cnt++;
            if (cl === 1'b1) ncl++;
        end
    endtask : wait_done
    task wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(negedge clock);
            cnt++;
        end while (tick !== 1'b1 && cnt < 30000);
    endtask : wait_tick
    initial begin
        #(80000 * 5);
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        check(pd, 1);
        check(result, 8'h00);
        $display("test reset done");
        for (int r = 0; r < 5; r++) begin
            set_ladders();
            i_core.write_ctrl(1'b1, 1'b1, r[2:0]);
            wait_done(n);
            check(n, 400);
            check(result, exp_q.pop_front());
            check(seg, kc >> 1);
            check(ncl, 1);
            i_core.write_ctrl(1'b1, 1'b0, 3'h0); // new rate must wait for a start
            if (r > 0) begin
                wait_tick(n);
                wait_tick(n);
                check(n, 25000 >> r);
            end
            $display("test rate %0d done", r);
        end
        set_ladders();
        i_core.write_ctrl(1'b1, 1'b1, 3'h4);
        repeat (100) @(negedge clock);
        check(busy, 1);
        set_ladders();
        i_core.write_ctrl(1'b1, 1'b1, 3'h4);
        wait_done(n);
        check(n, 400);
        check(result, exp_q.pop_front());
        check(ncl, 1);
        $display("test abort done");
        i_core.write_ctrl(1'b1, 1'b1, 3'h2);
        repeat (50) @(negedge clock);
        i_core.write_ctrl(1'b0, 1'b1, 3'h2);
        repeat (3) @(negedge clock);
        check(pd, 1);
        wait_done(n);
        check(n, 1000);
        $display("test disable done");
        stop_test();
    end
endmodule : half_flash_adc_sequencer_tb
